/* lodiag_defs.vh */
// Constants for the LED open/short diagnostics block
`ifndef LODIAG_DEFS_VH
`define LODIAG_DEFS_VH
`define LODIAG_NCH 48
`define LODIAG_RED_LSB 0
`define LODIAG_GRN_LSB 16
`define LODIAG_BLU_LSB 32
`define LODIAG_LINE_W 6
`define LODIAG_WARN_W 64
`define LODIAG_RM_SLOTS 3
`define LODIAG_TH_W 4
`define LODIAG_CLAMP_W 2
`define LODIAG_FLAGS_RST 48'h000000000000
`define LODIAG_WARN_RST 64'h0000000000000000
`endif

/* lodiag_slot.v */
// One stored open-line slot for ghost removal
`timescale 1ns/100ps
module lodiag_slot #(
  parameter LINE_W = 6,
  parameter NCH = 48
) (
  input wire clk, // Core clock
  input wire arst_n, // Async reset, active low
  input wire clr, // Drop the stored line
  input wire load, // Store line and channels
  input wire [LINE_W-1:0] line_in, // Line to store
  input wire [NCH-1:0] chan_in, // Open channels on that line
  input wire [LINE_W-1:0] cur_line, // Line now scanned
  output wire valid, // Slot holds a line
  output wire [LINE_W-1:0] line, // Stored line
  output wire [NCH-1:0] blank // Channels to blank now
);
  reg valid_q;
  reg [LINE_W-1:0] line_q;
  reg [NCH-1:0] chan_q;
  ////////////////////////////////////////////////////////////////
  // Slot storage; channels accumulate while the same line repeats
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      valid_q <= 1'b0;
      line_q <= {LINE_W{1'b0}};
      chan_q <= {NCH{1'b0}};
    end else if (clr) begin
      valid_q <= 1'b0;
      chan_q <= {NCH{1'b0}};
    end else if (load) begin
      valid_q <= 1'b1;
      line_q <= line_in;
      chan_q <= (valid_q ? chan_q : {NCH{1'b0}}) | chan_in;
    end
  end
  assign valid = valid_q;
  assign line = line_q;
  assign blank = (valid_q && line_q == cur_line) ? chan_q : {NCH{1'b0}};
endmodule

/* lodiag_core.v */
// LED open/short fault capture, flag latching, readback and open-line blanking
`timescale 1ns/100ps
`include "lodiag_defs.vh"
// Notes on behaviour
// R1: Open flag set when output above threshold
// R2: Short flag set when output below threshold
// R3: Short comparator used only while channel on
// R4: Open comparator used only while channel on
// R5: Open fault records scan line and channel
// R6: Open flags latched every segment end
// R7: Open bits: red 0-15, green, blue
// R8: Short fault records scan line and channel
// R9: Short flags latched every segment end
// R10: Short bits use the same colour layout
// R11: Controller enables readback before reading flags
// R12: Controller waits one sub-period, step two-three
// R13: Removal enable bit turns ghost removal on
// R14: Blank channels on stored lines until cleared
// R15: Store at most first three open lines
// R16: Fourth and later lines are not blanked
// R17: Per-colour short thresholds select detection level
// R18: Short ghost setting drives clamp level
// R19: Reset clears flags, warnings, stored lines
module lodiag_core #(
  parameter NCH = `LODIAG_NCH,
  parameter LINE_W = `LODIAG_LINE_W,
  parameter WARN_W = `LODIAG_WARN_W,
  parameter TH_W = `LODIAG_TH_W,
  parameter CLAMP_W = `LODIAG_CLAMP_W
) (
  input wire clk, // Grayscale clock, 10 MHz
  input wire arst_n, // Device reset, active low
  input wire [NCH-1:0] open_cmp, // Raw open comparators, async
  input wire [NCH-1:0] short_cmp, // Raw short comparators, async
  input wire [NCH-1:0] chan_on, // Channel output on, same clock
  input wire [LINE_W-1:0] scan_line, // Current scan line
  input wire seg_end, // One-cycle pulse at end of segment
  input wire fault_readback_enable, // Readback allowed
  input wire open_ghost_removal_enable, // Open removal enable
  input wire [CLAMP_W-1:0] short_ghost_removal_setting, // Clamp code
  input wire [TH_W-1:0] red_short_threshold, // Red short threshold code
  input wire [TH_W-1:0] green_short_threshold, // Green short threshold code
  input wire [TH_W-1:0] blue_short_threshold, // Blue short threshold code
  output reg [NCH-1:0] led_open_flags, // Open flag register readback
  output reg [NCH-1:0] led_short_flags, // Short flag register readback
  output reg [WARN_W-1:0] open_line_warning, // Lines with open LEDs
  output reg [WARN_W-1:0] short_line_warning, // Lines with shorted LEDs
  output reg readback_valid, // Readback data is valid
  output reg [NCH-1:0] chan_blank, // Force channel off
  output reg [CLAMP_W-1:0] clamp_level, // Unselected-line clamp code
  output reg [3*TH_W-1:0] short_vth_sel // Blue,green,red threshold codes
);
  localparam NSLOT = `LODIAG_RM_SLOTS;
  reg [NCH-1:0] open_s1_q, open_s2_q, short_s1_q, short_s2_q;
  reg [NCH-1:0] open_acc_q, short_acc_q;
  reg [NCH-1:0] open_flags_q, short_flags_q;
  reg [WARN_W-1:0] open_warn_q, short_warn_q;
  reg [NCH-1:0] open_line_q;
  reg [LINE_W-1:0] prev_line_q;
  reg rm_en_q;
  wire [NCH-1:0] open_hit, short_hit;
  wire [NSLOT-1:0] slot_valid;
  wire [NSLOT*LINE_W-1:0] slot_line;
  wire [NSLOT*NCH-1:0] slot_blank;
  wire line_change;
  reg [NSLOT-1:0] slot_load;
  reg line_known;
  reg [NCH-1:0] blank_d;
  integer i;
  ////////////////////////////////////////////////////////////////
  // Comparators are analog, so two flops before anyone looks
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      open_s1_q <= {NCH{1'b0}};
      open_s2_q <= {NCH{1'b0}};
      short_s1_q <= {NCH{1'b0}};
      short_s2_q <= {NCH{1'b0}};
    end else begin
      open_s1_q <= open_cmp;
      open_s2_q <= open_s1_q;
      short_s1_q <= short_cmp;
      short_s2_q <= short_s1_q;
    end
  end
  // Results count only in on time; off-time values are junk
  assign open_hit = open_s2_q & chan_on; // R1 R4
  assign short_hit = short_s2_q & chan_on; // R2 R3
  ////////////////////////////////////////////////////////////////
  // Per-segment accumulation and segment-end latch; bit n is channel n,
  // so red/green/blue fall on 0-15/16-31/32-47 directly
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      open_acc_q <= {NCH{1'b0}}; // R19
      short_acc_q <= {NCH{1'b0}};
      open_flags_q <= `LODIAG_FLAGS_RST; // R19
      short_flags_q <= `LODIAG_FLAGS_RST;
    end else if (seg_end) begin
      // Hits in the closing cycle are folded in, not lost
      open_flags_q <= open_acc_q | open_hit; // R6 R7
      short_flags_q <= short_acc_q | short_hit; // R9 R10
      open_acc_q <= {NCH{1'b0}};
      short_acc_q <= {NCH{1'b0}};
    end else begin
      open_acc_q <= open_acc_q | open_hit;
      short_acc_q <= short_acc_q | short_hit;
    end
  end
  ////////////////////////////////////////////////////////////////
  // Line warnings: sticky per line until reset
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      open_warn_q <= `LODIAG_WARN_RST; // R19
      short_warn_q <= `LODIAG_WARN_RST;
    end else begin
      if (|open_hit)
        open_warn_q[scan_line] <= 1'b1; // R5
      if (|short_hit)
        short_warn_q[scan_line] <= 1'b1; // R8
    end
  end
  ////////////////////////////////////////////////////////////////
  // Open channels seen on the current line; the removal slots take open_hit instead
  assign line_change = (scan_line != prev_line_q);
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      prev_line_q <= {LINE_W{1'b0}};
      open_line_q <= {NCH{1'b0}};
      rm_en_q <= 1'b0;
    end else begin
      prev_line_q <= scan_line;
      open_line_q <= line_change ? open_hit : (open_line_q | open_hit);
      rm_en_q <= open_ghost_removal_enable; // R13
    end
  end
  ////////////////////////////////////////////////////////////////
  // Slot choice: refresh a slot already holding this line, else take the
  // lowest free one; with all three full the line is dropped
  always @* begin
    slot_load = {NSLOT{1'b0}};
    line_known = 1'b0;
    for (i = 0; i < NSLOT; i = i + 1) begin
      if (slot_valid[i] && slot_line[i*LINE_W +: LINE_W] == scan_line) begin
        line_known = 1'b1;
        slot_load[i] = rm_en_q && (|open_hit);
      end
    end
    if (!line_known && rm_en_q && (|open_hit)) begin
      if (!slot_valid[0])
        slot_load[0] = 1'b1; // R15
      else if (!slot_valid[1])
        slot_load[1] = 1'b1; // R15
      else if (!slot_valid[2])
        slot_load[2] = 1'b1; // R15 R16
    end
  end
  genvar g;
  generate
    for (g = 0; g < NSLOT; g = g + 1) begin : slot
      lodiag_slot #(
        .LINE_W(LINE_W),
        .NCH(NCH)
      ) u_slot (
        .clk(clk),
        .arst_n(arst_n),
        .clr(!rm_en_q), // R14
        .load(slot_load[g]),
        .line_in(scan_line),
        .chan_in(open_hit),
        .cur_line(scan_line),
        .valid(slot_valid[g]),
        .line(slot_line[g*LINE_W +: LINE_W]),
        .blank(slot_blank[g*NCH +: NCH])
      );
    end
  endgenerate
  // Merge slot blanking; only stored lines blank, so later lines still ghost
  always @* begin
    blank_d = {NCH{1'b0}};
    for (i = 0; i < NSLOT; i = i + 1)
      blank_d = blank_d | slot_blank[i*NCH +: NCH]; // R14 R16
  end
  ////////////////////////////////////////////////////////////////
  // Registered outputs; flag readback is gated by the enable so the
  // controller only sees data once it set the enable first
  always @(posedge clk or negedge arst_n) begin
    if (!arst_n) begin
      led_open_flags <= {NCH{1'b0}};
      led_short_flags <= {NCH{1'b0}};
      open_line_warning <= {WARN_W{1'b0}};
      short_line_warning <= {WARN_W{1'b0}};
      readback_valid <= 1'b0;
      chan_blank <= {NCH{1'b0}};
      clamp_level <= {CLAMP_W{1'b0}};
      short_vth_sel <= {3*TH_W{1'b0}};
    end else begin
      readback_valid <= fault_readback_enable; // R11
      led_open_flags <= fault_readback_enable ? open_flags_q : {NCH{1'b0}}; // R11
      led_short_flags <= fault_readback_enable ? short_flags_q : {NCH{1'b0}};
      open_line_warning <= open_warn_q;
      short_line_warning <= short_warn_q;
      chan_blank <= rm_en_q ? blank_d : {NCH{1'b0}}; // R14
      clamp_level <= short_ghost_removal_setting; // R18
      short_vth_sel <= {blue_short_threshold, green_short_threshold,
                        red_short_threshold}; // R17
    end
  end
endmodule

/* lodiag_chk.sv */
// Port assertions for the LED open/short diagnostics block
`timescale 1ns/100ps
module lodiag_chk (
  input wire clk, // Clock
  input wire arst_n, // Reset
  input wire seg_end, // Segment end
  input wire fault_readback_enable, // Rb on
  input wire readback_valid, // Rb valid
  input wire [47:0] led_open_flags, // Open flags
  input wire [47:0] led_short_flags, // Short flags
  input wire [63:0] open_line_warning, // Open lines
  input wire [63:0] short_line_warning, // Short lines
  input wire open_ghost_removal_enable, // Removal on
  input wire [47:0] chan_blank, // Blanking
  input wire [1:0] short_ghost_removal_setting, // Clamp in
  input wire [1:0] clamp_level, // Clamp out
  input wire [3:0] red_short_threshold, // Red
  input wire [3:0] green_short_threshold, // Green
  input wire [3:0] blue_short_threshold, // Blue
  input wire [11:0] short_vth_sel // Codes out
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  ////////////////////////////////////////////////////////////
  // Steady enable rules out output gating as the cause of a flag change
  sequence s_rb_steady;
    $stable(fault_readback_enable) [*3];
  endsequence
  sequence s_rb_off;
    !fault_readback_enable [*2];
  endsequence
  a_rb_zero: assert property (s_rb_off |-> !led_open_flags && !led_short_flags)
    else $error("flags shown with readback off");
  a_rb_copy: assert property ($changed(fault_readback_enable) |=> readback_valid == $past(fault_readback_enable))
    else $error("readback valid lags");
  a_oflag_hold: assert property (s_rb_steady ##0 !$past(seg_end, 2) |-> $stable(led_open_flags))
    else $error("open flags moved off segment end");
  a_sflag_hold: assert property (s_rb_steady ##0 !$past(seg_end, 2) |-> $stable(led_short_flags))
    else $error("short flags moved off segment end");
  // Warnings are sticky until reset
  a_owarn_sticky: assert property ((open_line_warning & $past(open_line_warning)) == $past(open_line_warning))
    else $error("open warning bit dropped");
  a_swarn_sticky: assert property ((short_line_warning & $past(short_line_warning)) == $past(short_line_warning))
    else $error("short warning bit dropped");
  a_blank_off: assert property (!open_ghost_removal_enable [*4] |-> chan_blank == 48'h0)
    else $error("blanking with removal off");
  a_clamp_pass: assert property ($stable(short_ghost_removal_setting) [*2] |-> clamp_level == short_ghost_removal_setting)
    else $error("clamp code wrong");
  a_vth_pass: assert property ($stable({blue_short_threshold, green_short_threshold, red_short_threshold}) [*2] |-> short_vth_sel == {blue_short_threshold, green_short_threshold, red_short_threshold})
    else $error("threshold codes wrong");
endmodule

/* lodiag_leds.sv */
// Comparator model of the LED array behind the channels
`timescale 1ns/100ps
module lodiag_leds (
  input wire [47:0] chan_on, // Driven
  input wire [47:0] open_mask, // Open LEDs
  input wire [47:0] short_mask, // Shorted LEDs
  input wire noise, // Off-time garbage
  output wire [47:0] open_cmp, // Open cmp
  output wire [47:0] short_cmp // Short cmp
);
  // Off channels give garbage only when asked, as real comparators may
  assign open_cmp = (open_mask & chan_on) | ({48{noise}} & ~chan_on);
  assign short_cmp = (short_mask & chan_on) | ({48{noise}} & ~chan_on);
endmodule

/* testbench.sv */
// Self-checking bench for the LED open/short diagnostics block
`timescale 1ns/100ps
module testbench;
  logic clk = 0;
  logic arst_n;
  logic seg_end = 0, fault_readback_enable = 0, open_ghost_removal_enable = 0, noise = 0;
  logic [1:0] short_ghost_removal_setting = 2'h0;
  logic [3:0] red_short_threshold = 4'h0, green_short_threshold = 4'h0, blue_short_threshold = 4'h0;
  logic [5:0] scan_line = 6'h0;
  logic [47:0] chan_on = 48'h0, open_mask = 48'h0, short_mask = 48'h0;
  logic [47:0] open_cmp, short_cmp, led_open_flags, led_short_flags, chan_blank;
  logic [63:0] open_line_warning, short_line_warning;
  logic readback_valid;
  logic [1:0] clamp_level;
  logic [11:0] short_vth_sel;
  int fail_count = 0, n_checks = 0, cycles = 0;
  int ln[4] = '{3, 9, 17, 40};
  int ch[4] = '{5, 20, 40, 47};
  lodiag_core i_lodiag_core (.*);
  lodiag_leds i_lodiag_leds (.chan_on(chan_on), .open_mask(open_mask), .short_mask(short_mask),
    .noise(noise), .open_cmp(open_cmp), .short_cmp(short_cmp));
  always #50 clk = ~clk;
  ////////////////////////////////////////////////////////////
  // Run ceiling, far above the roughly 80 cycles the tests need
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 1000) begin
      fail_count++;
      final_report();
    end
  end
  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(negedge clk);
  endtask
  // Drops channels after the pulse so stale synced hits cannot leak forward
  task automatic seg(input logic [5:0] l, input logic [47:0] om, sm, on);
    scan_line = l;
    open_mask = om;
    short_mask = sm;
    chan_on = on;
    cyc(6);
    seg_end = 1;
    cyc(1);
    seg_end = 0;
    chan_on = 48'h0;
    cyc(3);
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask
  ////////////////////////////////////////////////////////////
  initial begin
    arst_n = 0;
    cyc(4);
    chk(led_open_flags, 64'h0);
    chk(open_line_warning | short_line_warning, 64'h0);
    arst_n = 1;
    short_ghost_removal_setting = 2'h2;
    red_short_threshold = 4'h3;
    green_short_threshold = 4'hA;
    blue_short_threshold = 4'hC;
    fault_readback_enable = 1;
    open_ghost_removal_enable = 1;
    cyc(3);
    chk(clamp_level, 64'h2);
    chk(short_vth_sel, 64'hCA3);
    chk(readback_valid, 64'h1);
    $display("config test done");
    for (int i = 0; i < 4; i++) begin
      seg(ln[i][5:0], 48'h1 << ch[i], 48'h0, 48'hFFFFFFFFFFFF);
      chk(led_open_flags, 48'h1 << ch[i]);
    end
    chk(open_line_warning, 64'h0000010000020208);
    for (int i = 0; i < 4; i++) begin
      scan_line = ln[i][5:0];
      cyc(3);
      chk(chan_blank, i < 3 ? 48'h1 << ch[i] : 48'h0);
    end
    $display("open test done");
    noise = 1;
    seg(6'h7, 48'h0, 48'h1 << 33, ~(48'h1 << 34));
    chk(led_short_flags, 48'h1 << 33);
    chk(led_open_flags, 64'h0);
    chk(short_line_warning, 64'h80);
    $display("short test done");
    fault_readback_enable = 0;
    cyc(3);
    chk(led_short_flags, 64'h0);
    chk(readback_valid, 64'h0);
    open_ghost_removal_enable = 0;
    cyc(5);
    open_ghost_removal_enable = 1;
    scan_line = 6'h3;
    cyc(3);
    chk(chan_blank, 64'h0);
    $display("disable test done");
    final_report();
  end
endmodule
bind lodiag_core lodiag_chk i_chk (.*);
